/* design/gpc_port.sv */
// Purpose: one 8-pin port: drive modes, slew, edge interrupt unit
// Assumes: pin inputs synchronous in timing only, resynchronised inside
// Notes: apb slave, zero wait states, unmapped reads return zero
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module gpc_port #(
  parameter int NPINS = gpc_pkg::NPINS,
  parameter int NOE = gpc_pkg::NOE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NOE-1:0] aux_oe,
  input wire logic [NPINS-1:0] periph_out,
  input wire logic [1:0] nv_rst_cfg,
  input wire logic sleep,
  output gpc_pkg::gpc_pad_s pad,
  output logic [NPINS-1:0] pin_reg_hi,
  output gpc_pkg::gpc_ana_s ana,
  output logic [NPINS-1:0] din,
  output logic irq
);
  logic [NPINS-1:0] data_reg, slw_reg, bie_reg, ibdis_reg, byp_reg;
  logic [NPINS-1:0] reg_hi_reg, istat_reg, sync1_reg, sync2_reg, prev_reg;
  logic [NPINS-1:0] dm0_reg, dm1_reg, dm2_reg;
  logic [NPINS*2-1:0] itype_reg;
  logic [NPINS*4-1:0] oesel_reg;
  logic [4:0] cfg_reg;
  logic [1:0] rstcfg_reg;
  logic nv_load_reg;
  logic [NPINS-1:0] edge_hit, rd_clr;
  gpc_pkg::gpc_pad_s pad_next;
  logic [31:0] rd_next;
  logic wr_en, rd_en;

  function automatic logic [NPINS-1:0] pick(input logic [31:0] w);
    pick = w[NPINS-1:0];
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // registers written by software; nv reset data loaded once after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= '0;
      dm0_reg <= '0;
      dm1_reg <= '0;
      dm2_reg <= '0;
      slw_reg <= '0;
      bie_reg <= '0;
      byp_reg <= '0;
      ibdis_reg <= '0;
      reg_hi_reg <= '0;
      itype_reg <= '0;
      oesel_reg <= '0;
      cfg_reg <= '0;
      rstcfg_reg <= gpc_pkg::RST_HIZ;
      nv_load_reg <= 1'b1;
    end else if (nv_load_reg) begin
      nv_load_reg <= 1'b0;
      rstcfg_reg <= nv_rst_cfg;
      // pull-up mode with data 1, pull-down mode with data 0
      if (nv_rst_cfg == gpc_pkg::RST_PU) begin
        dm1_reg <= '1;
        data_reg <= '1;
      end else if (nv_rst_cfg == gpc_pkg::RST_PD) begin
        dm1_reg <= '1;
        dm0_reg <= '1;
      end
    end else if (wr_en) begin
      unique case (paddr)
        gpc_pkg::OFF_DATA: data_reg <= pick(pwdata);
        gpc_pkg::OFF_DM0: dm0_reg <= pick(pwdata);
        gpc_pkg::OFF_DM1: dm1_reg <= pick(pwdata);
        gpc_pkg::OFF_DM2: dm2_reg <= pick(pwdata);
        gpc_pkg::OFF_SLW: slw_reg <= pick(pwdata);
        gpc_pkg::OFF_BIE: begin
          bie_reg <= pick(pwdata);
          byp_reg <= pwdata[NPINS*2-1:NPINS];
        end
        gpc_pkg::OFF_OESEL: oesel_reg <= pwdata[NPINS*4-1:0];
        gpc_pkg::OFF_IBDIS: ibdis_reg <= pick(pwdata);
        gpc_pkg::OFF_CFG: cfg_reg <= pwdata[4:0];
        gpc_pkg::OFF_ITYPE: itype_reg <= pwdata[NPINS*2-1:0];
        gpc_pkg::OFF_SIO: reg_hi_reg <= pick(pwdata);
        default: ;
      endcase
    end
  end

  // synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // edge detect has no sleep gating, so wake edges always register
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic rise, fall;
      logic [2:0] dm;
      logic oe_route, drv, outv, ib;
      assign rise = sync2_reg[g] && !prev_reg[g];
      assign fall = !sync2_reg[g] && prev_reg[g];
      // edges only, never levels
      assign edge_hit[g] = (rise && itype_reg[2*g]) ||
                           (fall && itype_reg[2*g+1]);
      assign rd_clr[g] = rd_en && (paddr == gpc_pkg::OFF_ISTAT);
      assign dm = {dm2_reg[g], dm1_reg[g], dm0_reg[g]};
      assign oe_route =
        aux_oe[oesel_reg[gpc_pkg::OESEL_W*g +: gpc_pkg::OESEL_W]];
      assign outv = byp_reg[g] ? periph_out[g] : data_reg[g];
      always_comb begin
        drv = 1'b0;
        pad_next.out[g] = outv;
        pad_next.oe[g] = 1'b0;
        pad_next.pu[g] = 1'b0;
        pad_next.pd[g] = 1'b0;
        unique case (gpc_pkg::gpc_dm_e'(dm))
          gpc_pkg::GPC_DM_AHIZ: drv = 1'b0;
          gpc_pkg::GPC_DM_DHIZ: drv = 1'b0;
          gpc_pkg::GPC_DM_PU: begin
            drv = !outv;
            pad_next.pu[g] = outv && !reg_hi_reg[g];
          end
          gpc_pkg::GPC_DM_PD: begin
            drv = outv;
            pad_next.pd[g] = !outv && !reg_hi_reg[g];
          end
          gpc_pkg::GPC_DM_ODL: drv = !outv;
          gpc_pkg::GPC_DM_ODH: drv = outv;
          gpc_pkg::GPC_DM_STRONG: drv = 1'b1;
          gpc_pkg::GPC_DM_PUPD: begin
            drv = 1'b0;
            pad_next.pu[g] = outv && !reg_hi_reg[g];
            pad_next.pd[g] = !outv && !reg_hi_reg[g];
          end
        endcase
        // bidirectional: inactive oe forces digital high-z
        if (bie_reg[g] && !oe_route) begin
          drv = 1'b0;
          pad_next.pu[g] = 1'b0;
          pad_next.pd[g] = 1'b0;
        end
        pad_next.oe[g] = drv;
        // slew only matters for strong/open-drain drivers
        pad_next.fast[g] = !slw_reg[g] && dm[2] && !(&dm);
        ib = (dm != gpc_pkg::GPC_DM_AHIZ) && !ibdis_reg[g];
        pad_next.ib_en[g] = ib;
      end
    end
  endgenerate

  // status: set wins over read-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= '0;
    end else begin
      istat_reg <= (istat_reg & ~rd_clr) | edge_hit;
    end
  end

  // single port request line toward the interrupt controller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((istat_reg & ~rd_clr) | edge_hit);
    end
  end

  // pad drive held in reset as analog high-z; no sleep term, state holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad <= '0;
      pin_reg_hi <= '0;
      ana <= '0;
      din <= '0;
    end else begin
      pad <= pad_next;
      pin_reg_hi <= reg_hi_reg;
      ana.lvttl <= cfg_reg[gpc_pkg::CFG_LVTTL];
      ana.vth_sel <= cfg_reg[gpc_pkg::CFG_VTH_LO +: 2];
      ana.hyst <= cfg_reg[gpc_pkg::CFG_HYST];
      ana.ag_ref <= cfg_reg[gpc_pkg::CFG_AGREF];
      din <= sync2_reg & pad_next.ib_en;
    end
  end

  always_comb begin
    rd_next = gpc_pkg::RD_ZERO;
    unique case (paddr)
      gpc_pkg::OFF_DATA: rd_next[NPINS-1:0] = data_reg;
      gpc_pkg::OFF_DM0: rd_next[NPINS-1:0] = dm0_reg;
      gpc_pkg::OFF_DM1: rd_next[NPINS-1:0] = dm1_reg;
      gpc_pkg::OFF_DM2: rd_next[NPINS-1:0] = dm2_reg;
      gpc_pkg::OFF_SLW: rd_next[NPINS-1:0] = slw_reg;
      gpc_pkg::OFF_BIE: rd_next[NPINS*2-1:0] = {byp_reg, bie_reg};
      gpc_pkg::OFF_OESEL: rd_next[NPINS*4-1:0] = oesel_reg;
      gpc_pkg::OFF_IBDIS: rd_next[NPINS-1:0] = ibdis_reg;
      gpc_pkg::OFF_CFG: rd_next[4:0] = cfg_reg;
      gpc_pkg::OFF_ITYPE: rd_next[NPINS*2-1:0] = itype_reg;
      gpc_pkg::OFF_ISTAT: rd_next[NPINS-1:0] = istat_reg;
      gpc_pkg::OFF_PS: rd_next[NPINS-1:0] = sync2_reg;
      gpc_pkg::OFF_SIO: rd_next[NPINS-1:0] = reg_hi_reg;
      gpc_pkg::OFF_RSTCFG: rd_next[1:0] = rstcfg_reg;
      default: rd_next = gpc_pkg::RD_ZERO;
    endcase
  end

  // loading in the setup phase lets prdata come from a flop with no wait state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= rd_next;
      end
    end
  end

  logic unused_sleep;
  assign unused_sleep = sleep;

  property p_edge_sets;
    @(posedge clk) disable iff (!rst_n)
      edge_hit[0] |=> istat_reg[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge lost");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      (|edge_hit) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no request");

  property p_sync;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |-> ##2 (sync2_reg == $past(pin_in, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth");

  property p_off;
    @(posedge clk) disable iff (!rst_n)
      (itype_reg[1:0] == 2'h0) |-> !edge_hit[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled pin hit");

  property p_bidir;
    @(posedge clk) disable iff (!rst_n)
      (bie_reg[0] && !aux_oe[oesel_reg[3:0]]) |=> !pad.oe[0];
  endproperty
  a_bidir: assert property (p_bidir) else $error("oe ignored");

  property p_regout;
    @(posedge clk) disable iff (!rst_n)
      reg_hi_reg[0] |=> !pad.pu[0] && !pad.pd[0];
  endproperty
  a_regout: assert property (p_regout) else $error("pull on reg");

  property p_ibdis;
    @(posedge clk) disable iff (!rst_n)
      ibdis_reg[0] |=> !pad.ib_en[0];
  endproperty
  a_ibdis: assert property (p_ibdis) else $error("buffer on");

  // sleep must not mask the status update, or no wake edge would be seen
  property p_sleep;
    @(posedge clk) disable iff (!rst_n)
      (sleep && edge_hit[0]) |=> istat_reg[0];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep edge lost");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      (rd_clr[0] && edge_hit[0]) |=> istat_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");

  property p_clr;
    @(posedge clk) disable iff (!rst_n)
      (rd_clr[0] && !edge_hit[0]) |=> !istat_reg[0];
  endproperty
  a_clr: assert property (p_clr) else $error("status kept");

  property p_irq_lvl;
    @(posedge clk) disable iff (!rst_n)
      irq == (|istat_reg);
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq level");

  property p_nv_load;
    @(posedge clk) disable iff (!rst_n)
      (nv_load_reg && (nv_rst_cfg == gpc_pkg::RST_PU)) |=>
        (&dm1_reg) && (&data_reg) && !(|dm0_reg);
  endproperty
  a_nv_load: assert property (p_nv_load) else $error("nv load");

  property p_strong;
    @(posedge clk) disable iff (!rst_n)
      (dm2_reg[0] && dm1_reg[0] && !dm0_reg[0] && !bie_reg[0]) |=> pad.oe[0];
  endproperty
  a_strong: assert property (p_strong) else $error("strong off");

  property p_ahiz;
    @(posedge clk) disable iff (!rst_n)
      !(dm2_reg[0] || dm1_reg[0] || dm0_reg[0]) |=> !pad.ib_en[0];
  endproperty
  a_ahiz: assert property (p_ahiz) else $error("analog buffer on");

  property p_level;
    @(posedge clk) disable iff (!rst_n)
      (sync2_reg[0] && prev_reg[0]) |-> !edge_hit[0];
  endproperty
  a_level: assert property (p_level) else $error("level hit");

  // a rise on pin 0 must show up as status and request one cycle later
  sequence s_rise0;
    !prev_reg[0] && sync2_reg[0] && itype_reg[0];
  endsequence

  sequence s_flag0;
    istat_reg[0] && irq;
  endsequence

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      s_rise0 |=> s_flag0;
  endproperty
  a_wake: assert property (p_wake) else $error("rise not flagged");

  property p_slew;
    @(posedge clk) disable iff (!rst_n)
      (dm2_reg[0] == 1'b0) |=> !pad.fast[0];
  endproperty
  a_slew: assert property (p_slew) else $error("slew on resistive");
endmodule // gpc_port

/* design/gpc_pkg.sv */
// Purpose: shared constants and types for the port pin control block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package gpc_pkg;
  localparam int NPINS = 8;
  localparam int NOE = 16;
  localparam int OESEL_W = 4;
  localparam int DM_W = 3;
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_DM0 = 12'h004;
  localparam logic [11:0] OFF_DM1 = 12'h008;
  localparam logic [11:0] OFF_DM2 = 12'h00C;
  localparam logic [11:0] OFF_SLW = 12'h010;
  localparam logic [11:0] OFF_BIE = 12'h014;
  localparam logic [11:0] OFF_OESEL = 12'h018;
  localparam logic [11:0] OFF_IBDIS = 12'h01C;
  localparam logic [11:0] OFF_CFG = 12'h020;
  localparam logic [11:0] OFF_ITYPE = 12'h024;
  localparam logic [11:0] OFF_ISTAT = 12'h028;
  localparam logic [11:0] OFF_PS = 12'h02C;
  localparam logic [11:0] OFF_SIO = 12'h030;
  localparam logic [11:0] OFF_RSTCFG = 12'h034;
  // cfg register fields
  localparam int CFG_LVTTL = 0;
  localparam int CFG_VTH_LO = 1;
  localparam int CFG_HYST = 3;
  localparam int CFG_AGREF = 4;
  // reset configuration codes
  localparam logic [1:0] RST_HIZ = 2'h0;
  localparam logic [1:0] RST_PU = 2'h1;
  localparam logic [1:0] RST_PD = 2'h2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    GPC_DM_AHIZ = 3'h0, GPC_DM_DHIZ = 3'h1, GPC_DM_PU = 3'h2,
    GPC_DM_PD = 3'h3, GPC_DM_ODL = 3'h4, GPC_DM_ODH = 3'h5,
    GPC_DM_STRONG = 3'h6, GPC_DM_PUPD = 3'h7
  } gpc_dm_e;
  typedef enum logic [1:0] {
    GPC_IT_OFF = 2'h0, GPC_IT_RISE = 2'h1, GPC_IT_FALL = 2'h2,
    GPC_IT_BOTH = 2'h3
  } gpc_it_e;
  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pu;
    logic [NPINS-1:0] pd;
    logic [NPINS-1:0] fast;
    logic [NPINS-1:0] ib_en;
  } gpc_pad_s;
  typedef struct packed {
    logic lvttl;
    logic [1:0] vth_sel;
    logic hyst;
    logic ag_ref;
  } gpc_ana_s;
endpackage

/* dv/gpc_pin_model.sv */
// Purpose: far side of the port pins, resolves each pin level
// Assumes: external drive is only applied to pins in high-z modes
// Notes: an undriven pin with no pull toggles, never holds a value
`timescale 1ns/1ps
module gpc_pin_model (
  input wire logic clk,
  input gpc_pkg::gpc_pad_s pad,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic alt = 1'b0;
  always @(posedge clk) alt <= ~alt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // external source only meets pins in mode 0 or 1
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pad.oe[i]) pin_in[i] = pad.out[i];
      else if (pad.pu[i]) pin_in[i] = 1'b1;
      else if (pad.pd[i]) pin_in[i] = 1'b0;
      else pin_in[i] = alt;
    end
  end
endmodule // gpc_pin_model

/* dv/gpc_port_tb.sv */
// Purpose: self-checking bench for the port pin control block
// Assumes: apb answers with no wait state, waits are still bounded
// Notes: pad outputs are registered, so checks wait three edges
`timescale 1ns/1ps
module gpc_port_tb;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq;
  logic [15:0] aux_oe = 16'h0000;
  logic [7:0] periph_out = 8'h00, pin_in, din, pin_reg_hi;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
  logic [1:0] nv_rst_cfg = gpc_pkg::RST_PU;
  gpc_pkg::gpc_pad_s pad;
  gpc_pkg::gpc_ana_s ana;
  int n_errors = 0, total_checks = 0;
  gpc_port DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .aux_oe(aux_oe),
    .periph_out(periph_out), .nv_rst_cfg(nv_rst_cfg), .sleep(sleep),
    .pad(pad), .pin_reg_hi(pin_reg_hi), .ana(ana), .din(din), .irq(irq));
  gpc_pin_model far_side (.clk(clk), .pad(pad), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [47:0] e, logic [47:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // pready and prdata are read at the rising edge, before it updates them
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      give_verdict();
    end
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task automatic wt(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {16'h0, e}, {16'h0, rd});
    chk("pslverr", 48'h0, {47'h0, pslverr});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic set_dm(logic [2:0] m);
    wt(gpc_pkg::OFF_DM0, {24'h0, {8{m[0]}}});
    wt(gpc_pkg::OFF_DM1, {24'h0, {8{m[1]}}});
    wt(gpc_pkg::OFF_DM2, {24'h0, {8{m[2]}}});
  endtask
  task automatic t_reset();
    repeat (6) @(posedge clk);
    chk("pad in reset", 48'h0, pad);
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rdc("dm1", gpc_pkg::OFF_DM1, 32'hFF);
    rdc("dm0", gpc_pkg::OFF_DM0, 32'h00);
    rdc("data", gpc_pkg::OFF_DATA, 32'hFF);
    wt(gpc_pkg::OFF_RSTCFG, 32'h0);
    rdc("rstcfg", gpc_pkg::OFF_RSTCFG, 32'h1);
    rdc("unmapped", 12'h0FC, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_modes();
    wt(gpc_pkg::OFF_DATA, 32'hA5);
    set_dm(3'h6);
    wt(gpc_pkg::OFF_SLW, 32'h0F);
    settle();
    chk("strong oe", 48'hFF, {40'h0, pad.oe});
    chk("strong out", 48'hA5, {40'h0, pad.out});
    chk("slew fast", 48'hF0, {40'h0, pad.fast});
    set_dm(3'h1);
    settle();
    chk("dhiz oe", 48'h0, {40'h0, pad.oe});
    chk("dhiz ib", 48'hFF, {40'h0, pad.ib_en});
    wt(gpc_pkg::OFF_IBDIS, 32'h3C);
    settle();
    chk("ib disable", 48'hC3, {40'h0, pad.ib_en});
    wt(gpc_pkg::OFF_IBDIS, 32'h00);
    $display("test modes done");
  endtask
  task automatic t_bidir();
    set_dm(3'h6);
    wt(gpc_pkg::OFF_OESEL, 32'h0000_00F3);
    wt(gpc_pkg::OFF_BIE, 32'h03);
    aux_oe <= 16'h8000;
    settle();
    chk("oe sel15", 48'h2, {46'h0, pad.oe[1:0]});
    aux_oe <= 16'h0008;
    settle();
    chk("oe sel3", 48'h1, {46'h0, pad.oe[1:0]});
    wt(gpc_pkg::OFF_BIE, 32'h00);
    $display("test bidir done");
  endtask
  task automatic t_sio();
    wt(gpc_pkg::OFF_DATA, 32'hFF);
    set_dm(3'h2);
    wt(gpc_pkg::OFF_SIO, 32'h01);
    wt(gpc_pkg::OFF_CFG, 32'h1B);
    settle();
    chk("reg hi", 48'h01, {40'h0, pin_reg_hi});
    chk("pull up", 48'hFE, {40'h0, pad.pu});
    chk("ana", 48'h17, {43'h0, ana});
    wt(gpc_pkg::OFF_SIO, 32'h00);
    $display("test sio done");
  endtask
  task automatic edge_run(logic [7:0] v, logic [31:0] e);
    int n;
    ext_val <= v;
    for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk);
    if (n == 10) n_errors++;
    repeat (3) @(posedge clk);
    chk("din", {40'h0, v}, {40'h0, din});
    rdc("istat", gpc_pkg::OFF_ISTAT, e);
    rdc("istat clr", gpc_pkg::OFF_ISTAT, 32'h0);
    chk("irq clr", 48'h0, {47'h0, irq});
  endtask
  task automatic t_irq();
    set_dm(3'h1);
    ext_en <= 8'hFF;
    sleep <= 1;
    wt(gpc_pkg::OFF_ITYPE, 32'h39);
    repeat (4) @(posedge clk);
    apb(1'b0, gpc_pkg::OFF_ISTAT, 32'h0);
    edge_run(8'hFF, 32'h05);
    edge_run(8'h00, 32'h06);
    $display("test irq done");
  endtask
  initial begin
    t_reset();
    t_modes();
    t_bidir();
    t_sio();
    t_irq();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule // gpc_port_tb
